/* File: banked_memory_address_map.sv */
// Program and data memory address map with banked register file.
// How it works
// - Fetch and data ports run in parallel.
// - Program counter is 13 bits, 14-bit words.
// - Large variant 8K words, small 4K words.
// - Addresses above implemented flash wrap around.
// - Reset starts execution at 0000h.
// - Accepted interrupt jumps fetch to 0004h.
// - Flag bits 6:5 select the data bank.
// - Each bank holds 128 byte offsets.
// - Low offsets are registers, upper offsets RAM.
// - Frequent registers are mirrored across banks.
// - Access directly or through indirect pointer.
// - Unimplemented locations read zero, ignore writes.
// - Offset zero slot redirects through the pointer.
`timescale 1ns/100ps
`default_nettype none
module banked_memory_address_map #(
   parameter int PROG_WORDS = banked_memory_pkg::BIG_PROG_WORDS
) (
   // Clock and control
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Program fetch path
   input wire logic pcAdvance,
   input wire logic pcLoad,
   input wire logic [banked_memory_pkg::PC_WIDTH-1:0] pcLoadValue,
   input wire logic irqAccept,
   output logic [banked_memory_pkg::PC_WIDTH-1:0] fetchAddr,
   output logic [banked_memory_pkg::PC_WIDTH-1:0] flashAddr,
   // Flash word from the program array, same clock
   input wire logic [banked_memory_pkg::INSTR_WIDTH-1:0] flashData,
   output logic [banked_memory_pkg::INSTR_WIDTH-1:0] instrWord,
   // Data operand path
   input wire logic dataRead,
   input wire logic dataWrite,
   input wire logic [banked_memory_pkg::OFFSET_WIDTH-1:0] dataOffset,
   input wire logic [banked_memory_pkg::BYTE_WIDTH-1:0] dataWrData,
   output logic [banked_memory_pkg::BYTE_WIDTH-1:0] dataRdData,
   output logic [banked_memory_pkg::DATA_ADDR_WIDTH-1:0] physAddr,
   // Core state seen by the core
   output logic [banked_memory_pkg::BYTE_WIDTH-1:0] coreFlags,
   output logic [banked_memory_pkg::BYTE_WIDTH-1:0] indirectPointer
);
   import banked_memory_pkg::*;

   localparam int GP_WORDS = 4 * 128;

   // ----------------------------------------
   // Design notes
   // ----------------------------------------
   // The fetch side and the operand side share no path, so both move
   // in the same enabled cycle.
   // The program counter always holds a wrapped value. Jumps, writes
   // of the low byte and increments all pass through the same mask, so
   // the smaller array never sees an address it does not have.
   // An accepted interrupt wins over a jump, and a jump over an
   // increment. A write to the low counter byte in the same cycle wins
   // over all three, as the operand path is evaluated last.
   // Only the core registers are held here. The other low offsets
   // belong to peripherals outside this block and read as zero, and
   // writes to them are dropped.
   // Offsets from 70h up in every bank fold onto bank 0, so the top
   // sixteen bytes give shared scratch space whatever the bank bits say.
   // The reported physical address is the unfolded one, so a monitor
   // can still tell which bank the core aimed at.
   // The indirect slot never stores anything. When the pointer itself
   // points back at the slot the access lands nowhere: reads give zero
   // and writes are lost, which avoids a loop through the pointer.
   // A read and a write in one cycle see the old contents, since every
   // read answers from the registered state.
   // The clock enable freezes every flop, the RAM included; reset acts
   // whatever the enable says.

   typedef struct packed {
      logic [PC_WIDTH-1:0] pc;
      logic [PC_WIDTH-1:0] flashAddr;
      logic [INSTR_WIDTH-1:0] instr;
      logic [7:0] flags;
      logic [7:0] pointer;
      logic [7:0] pcLatch;
      logic [7:0] rdData;
      logic [DATA_ADDR_WIDTH-1:0] physAddr;
   } state_s;

   state_s cur;
   state_s next_cur;
   logic [7:0] gpRam [0:GP_WORDS-1];
   logic [DATA_ADDR_WIDTH-1:0] resolved;
   logic ramHit;
   logic [DATA_ADDR_WIDTH-1:0] ramIndex;

   // ----------------------------------------
   // Address functions
   // ----------------------------------------
   // Upper address bits beyond the array are dropped, never faulted.
   function automatic logic [PC_WIDTH-1:0] wrapProg(
      input logic [PC_WIDTH-1:0] a);
      wrapProg = a & PC_WIDTH'(PROG_WORDS - 1);
   endfunction : wrapProg

   // Shared upper RAM is mirrored into bank 0; all other GP offsets stay in their own bank.
   function automatic logic [DATA_ADDR_WIDTH-1:0] ramFold(
      input logic [DATA_ADDR_WIDTH-1:0] a);
      if (a[6:0] >= OFS_SHARED_FIRST) begin
         ramFold = {2'b00, a[6:0]};
      end else begin
         ramFold = a;
      end
   endfunction : ramFold

   // Bank bits sit directly above the offset carried in the instruction.
   function automatic logic [DATA_ADDR_WIDTH-1:0] directAddr(
      input logic [BYTE_WIDTH-1:0] flags,
      input logic [OFFSET_WIDTH-1:0] ofs);
      directAddr = {flags[BANK_SELECT_HIGH_BIT],
                    flags[BANK_SELECT_LOW_BIT], ofs};
   endfunction : directAddr

   // ----------------------------------------
   // Data address resolution
   // ----------------------------------------
   always_comb begin
      // Offset zero has no storage; the pointer supplies the address.
      if (dataOffset == OFS_INDIRECT_SLOT) begin
         resolved = {cur.flags[7], cur.pointer};
      end else begin
         resolved = directAddr(cur.flags, dataOffset);
      end
      ramHit = (resolved[6:0] >= OFS_GP_FIRST);
      ramIndex = ramFold(resolved);
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_cur = cur;
      // Fetch runs every cycle independently of the data port.
      next_cur.flashAddr = wrapProg(cur.pc);
      next_cur.instr = flashData;
      if (irqAccept) begin
         next_cur.pc = IRQ_VECTOR;
      end else if (pcLoad) begin
         next_cur.pc = wrapProg(pcLoadValue);
      end else if (pcAdvance) begin
         next_cur.pc = wrapProg(cur.pc + PC_WIDTH'(1));
      end
      next_cur.physAddr = resolved;
      if (dataRead) begin
         next_cur.rdData = 8'h00;
         if (ramHit) begin
            next_cur.rdData = gpRam[ramIndex];
         end else begin
            // Core registers answer from every bank.
            case (resolved[6:0])
               OFS_PC_LOW: next_cur.rdData = cur.pc[7:0];
               OFS_FLAGS: next_cur.rdData = cur.flags;
               OFS_POINTER: next_cur.rdData = cur.pointer;
               OFS_PC_LATCH: next_cur.rdData = cur.pcLatch;
               default: next_cur.rdData = 8'h00;
            endcase
         end
      end
      if (dataWrite && !ramHit) begin
         case (resolved[6:0])
            OFS_PC_LOW: begin
               next_cur.pc = wrapProg({cur.pcLatch[PC_LATCH_BITS-1:0],
                                       dataWrData});
            end
            OFS_FLAGS: next_cur.flags = dataWrData;
            OFS_POINTER: next_cur.pointer = dataWrData;
            OFS_PC_LATCH: begin
               next_cur.pcLatch = {3'b000,
                                   dataWrData[PC_LATCH_BITS-1:0]};
            end
            default: next_cur.pcLatch = cur.pcLatch;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Reset is checked before the enable, so a frozen core can still be
   // brought back to the reset vector.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cur <= '0;
         cur.pc <= RESET_VECTOR;
         cur.flags <= FLAGS_RESET;
         cur.pointer <= POINTER_RESET;
         cur.pcLatch <= PC_LATCH_RESET;
      end else if (clkEn) begin
         cur <= next_cur;
      end
   end

   // RAM has no reset, as static RAM powers up undefined.
   // Software must write a location before it trusts a read from it;
   // clearing the array here would cost a long reset sequence.
   always_ff @(posedge ref_clk) begin
      if (clkEn && dataWrite && ramHit) begin
         gpRam[ramIndex] <= dataWrData;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign fetchAddr = cur.pc;
   assign flashAddr = cur.flashAddr;
   assign instrWord = cur.instr;
   assign dataRdData = cur.rdData;
   assign physAddr = cur.physAddr;
   assign coreFlags = cur.flags;
   assign indirectPointer = cur.pointer;
endmodule : banked_memory_address_map
`default_nettype wire

/* File: banked_memory_address_map_assertions.sv */
// Port checker for the banked memory address map.
`timescale 1ns/100ps
`default_nettype none
module banked_memory_checker #(
   parameter int PROG_WORDS = 8192
) (
   // Clock and control
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clkEn,
   // Fetch path
   input wire logic pcAdvance,
   input wire logic pcLoad,
   input wire logic irqAccept,
   input wire logic [12:0] pcLoadValue,
   input wire logic [12:0] fetchAddr,
   input wire logic [12:0] flashAddr,
   input wire logic [13:0] flashData,
   input wire logic [13:0] instrWord,
   // Data path
   input wire logic dataRead,
   input wire logic dataWrite,
   input wire logic [6:0] dataOffset,
   input wire logic [7:0] dataWrData,
   input wire logic [7:0] dataRdData,
   input wire logic [7:0] coreFlags,
   input wire logic [7:0] indirectPointer,
   input wire logic [8:0] physAddr
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic acc = clkEn && (dataRead || dataWrite);
   a_reset_vector: assert property (disable iff (1'b0)
      rst |=> fetchAddr == 13'h0000) else $error("pc not at reset vector");
   a_irq_vector: assert property (clkEn && irqAccept
      |=> fetchAddr == 13'h0004) else $error("pc not at irq vector");
   a_pc_advance: assert property (clkEn && pcAdvance && !pcLoad &&
      !irqAccept |=> fetchAddr % PROG_WORDS == ($past(fetchAddr) + 1) %
      PROG_WORDS) else $error("pc did not advance");
   a_pc_jump: assert property (clkEn && pcLoad && !irqAccept |=>
      fetchAddr % PROG_WORDS == $past(pcLoadValue) % PROG_WORDS)
      else $error("pc jump wrong");
   a_flash_wrap: assert property (clkEn |=>
      flashAddr == $past(fetchAddr) % PROG_WORDS) else $error("flash addr");
   a_instr_copy: assert property (clkEn |=>
      instrWord == $past(flashData)) else $error("instr word");
   a_bank_offset: assert property (acc &&
      dataOffset inside {[7'h20:7'h6f]}
      |=> physAddr == {$past(coreFlags[6:5]), $past(dataOffset)})
      else $error("banked address wrong");
   a_indirect_slot: assert property (acc && dataOffset == 7'h00
      |=> physAddr == {$past(coreFlags[7]), $past(indirectPointer)})
      else $error("indirect address wrong");
   a_unimpl_zero: assert property (clkEn && dataRead &&
      dataOffset inside {7'h01, [7'h05:7'h09]} |=> dataRdData == 8'h00)
      else $error("unimplemented read not zero");
   a_pointer_write: assert property (acc && dataWrite &&
      dataOffset == 7'h04 |=> indirectPointer == $past(dataWrData))
      else $error("pointer write lost");
   a_flags_write: assert property (acc && dataWrite &&
      dataOffset == 7'h03 |=> coreFlags == $past(dataWrData))
      else $error("flags write lost");
endmodule : banked_memory_checker
bind banked_memory_address_map banked_memory_checker
   #(.PROG_WORDS(PROG_WORDS)) u_checker (
   .ref_clk(ref_clk),
   .rst(rst),
   .clkEn(clkEn),
   .pcAdvance(pcAdvance),
   .pcLoad(pcLoad),
   .irqAccept(irqAccept),
   .pcLoadValue(pcLoadValue),
   .fetchAddr(fetchAddr),
   .flashAddr(flashAddr),
   .flashData(flashData),
   .instrWord(instrWord),
   .dataRead(dataRead),
   .dataWrite(dataWrite),
   .dataOffset(dataOffset),
   .dataWrData(dataWrData),
   .dataRdData(dataRdData),
   .coreFlags(coreFlags),
   .indirectPointer(indirectPointer),
   .physAddr(physAddr)
);
`default_nettype wire

/* File: banked_memory_address_map_tb_top.sv */
// Self-checking bench for the banked memory address map.
`timescale 1ns/100ps
`default_nettype none
module banked_memory_address_map_tb_top;
   import banked_memory_pkg::*;
   localparam int PW = SMALL_PROG_WORDS;
   logic ref_clk = 0, rst = 1, clkEn = 1, pcAdvance = 0, pcLoad = 0;
   logic irqAccept = 0, dataRead = 0, dataWrite = 0;
   logic [12:0] pcLoadValue = 0, fetchAddr, flashAddr;
   logic [13:0] flashData, instrWord;
   logic [6:0] dataOffset = 0;
   logic [7:0] dataWrData = 0, dataRdData, coreFlags, indirectPointer;
   logic [8:0] physAddr;
   int error_cnt = 0, compares = 0, pcm, fm, pm, lm, fa, iw, op, val, en;
   int mem [512];
   always #20 ref_clk = ~ref_clk;
   banked_memory_address_map #(.PROG_WORDS(PW)) DUT (
      .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
      .pcAdvance(pcAdvance), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
      .irqAccept(irqAccept), .fetchAddr(fetchAddr), .flashAddr(flashAddr),
      .flashData(flashData), .instrWord(instrWord), .dataRead(dataRead),
      .dataWrite(dataWrite), .dataOffset(dataOffset),
      .dataWrData(dataWrData), .dataRdData(dataRdData),
      .physAddr(physAddr), .coreFlags(coreFlags),
      .indirectPointer(indirectPointer));
   program_flash_model flash (.flashAddr(flashAddr), .flashData(flashData));
   task automatic chk_ins(input string n, input logic [13:0] e, g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_ins
   task automatic chk_adr(input string n, input logic [12:0] e, g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_adr
   task automatic chk_dat(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk_dat
   task automatic end_of_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   task automatic acc(input bit wr, input int off, input int d);
      int a;
      int r;
      int e;
      if (off == 0) a = (fm >> 7) * 256 + pm;
      else a = ((fm >> 5) & 3) * 128 + off;
      r = a % 128;
      d = d & 'hff;
      @(posedge ref_clk);
      dataWrite <= wr;
      dataRead <= !wr;
      dataOffset <= off[6:0];
      dataWrData <= d[7:0];
      @(posedge ref_clk);
      dataWrite <= 0;
      dataRead <= 0;
      if (r >= 'h70) e = mem[r];
      else if (r >= 32) e = mem[a];
      else if (r == 2) e = pcm % 256;
      else if (r == 3) e = fm;
      else if (r == 4) e = pm;
      else if (r == 10) e = lm;
      else e = 0;
      if (wr && r >= 'h70) mem[r] = d;
      else if (wr && r >= 32) mem[a] = d;
      if (wr && r == 2) pcm = (lm * 256 + d) % PW;
      if (wr && r == 3) fm = d;
      if (wr && r == 4) pm = d;
      if (wr && r == 10) lm = d & 'h1f;
      #1 chk_adr("physAddr", a, {4'h0, physAddr});
      if (!wr) chk_dat("dataRdData", e, dataRdData);
      chk_dat("coreFlags", fm, coreFlags);
      chk_dat("indirectPointer", pm, indirectPointer);
      chk_adr("fetchAddr", pcm, fetchAddr);
   endtask : acc
   task automatic do_reset;
      @(posedge ref_clk);
      {rst, clkEn, pcAdvance, pcLoad, irqAccept} <= 5'h18;
      repeat (10) @(posedge ref_clk);
      rst <= 0;
      #1 chk_adr("fetchAddr", 0, fetchAddr);
      fm = 'h18;
      pm = 0;
      lm = 0;
      pcm = 0;
   endtask : do_reset
   initial begin
      void'($urandom(4));
      do_reset();
      $display("test reset done");
      // Random jumps above 4K words must fold onto the small array.
      fa = 0;
      iw = 'h2000 ^ 'h2a5a;
      for (int i = 0; i < 300; i++) begin
         @(posedge ref_clk);
         op = $urandom % 4;
         val = $urandom % 8192;
         en = $urandom % 8 != 0;
         clkEn <= en[0];
         pcAdvance <= op == 0;
         pcLoad <= op == 1;
         irqAccept <= op == 2;
         pcLoadValue <= val[12:0];
         #1 chk_adr("fetchAddr", pcm, fetchAddr);
         chk_adr("flashAddr", fa, flashAddr);
         chk_ins("instrWord", iw, instrWord);
         if (en) begin
            iw = ('h2000 | fa) ^ 'h2a5a;
            fa = pcm;
         end
         if (en && op == 2) pcm = 4;
         else if (en && op == 1) pcm = val % PW;
         else if (en && op == 0) pcm = (pcm + 1) % PW;
      end
      $display("test program counter done");
      do_reset();
      // Each bank is written first and read back afterwards.
      for (int b = 0; b < 8; b++) begin
         acc(1, 3, (b % 4) << 5);
         acc(b < 4, 'h20, $urandom);
         acc(b < 4, 'h7f, $urandom);
         acc(b < 4, 5, 'hff);
      end
      acc(1, 'h0f, 0);
      acc(0, 'h0f, 0);
      acc(1, 4, 'ha3);
      acc(1, 0, $urandom);
      acc(1, 3, 'h20);
      acc(0, 'h23, 0);
      acc(0, 4, 0);
      acc(0, 0, 0);
      acc(1, 'h0a, 'hff);
      acc(1, 2, 'h34);
      acc(0, 2, 0);
      acc(0, 'h0a, 0);
      $display("test data memory done");
      end_of_test();
   end
   initial begin
      #(40 * 3000);
      error_cnt++;
      end_of_test();
   end
endmodule : banked_memory_address_map_tb_top
`default_nettype wire

/* File: banked_memory_pkg.sv */
// Constants for the banked memory address map.
package banked_memory_pkg;
   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int PC_WIDTH = 13;
   localparam int INSTR_WIDTH = 14;
   localparam int DATA_ADDR_WIDTH = 9;
   localparam int OFFSET_WIDTH = 7;
   localparam int BYTE_WIDTH = 8;
   localparam int BIG_PROG_WORDS = 8192;
   localparam int SMALL_PROG_WORDS = 4096;
   // ----------------------------------------
   // Vectors and register offsets
   // ----------------------------------------
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam logic [6:0] OFS_INDIRECT_SLOT = 7'h00;
   localparam logic [6:0] OFS_PC_LOW = 7'h02;
   localparam logic [6:0] OFS_FLAGS = 7'h03;
   localparam logic [6:0] OFS_POINTER = 7'h04;
   localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
   localparam logic [6:0] OFS_GP_FIRST = 7'h20;
   localparam logic [6:0] OFS_SHARED_FIRST = 7'h70;
   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int BANK_SELECT_HIGH_BIT = 6;
   localparam int BANK_SELECT_LOW_BIT = 5;
   localparam int PC_LATCH_BITS = 5;
   localparam logic [7:0] FLAGS_RESET = 8'h18;
   localparam logic [7:0] PC_LATCH_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
endpackage : banked_memory_pkg

/* File: program_flash_model.sv */
// Program flash array model answering fetch addresses.
`timescale 1ns/100ps
`default_nettype none
module program_flash_model (
   // Fetch address in, word out
   input wire logic [12:0] flashAddr,
   output logic [13:0] flashData
);
   // A distinct word per address, so a stale or misrouted fetch shows.
   assign flashData = {1'b1, flashAddr} ^ 14'h2a5a;
endmodule : program_flash_model
`default_nettype wire
